// File: src/cts_capture_timing.sv
`timescale 1ns/1ps
`include "cts_regs.svh"

// Contract
// [RQ1] Keep marks of the last 64 highlights; only a string's final character marks.
// [RQ2] Five interval timers, each reaching 65,535 milliseconds.
// [RQ3] Stamps go with data into a 768K FIFO; timers count stamp time.
// [RQ4] Timers clear at program start and on a reset command.
// [RQ5] Stop-timer or stop-all halts a timer and keeps its value.
// [RQ6] Open flag and address share a mark; last data, check, close share one.
// [RQ7] Timing off shrinks cursor range from 65,536 to 64 units, absolute.
// [RQ8] Data captured with timing off gives no timer measurement.
// [RQ9] With timing on, one stamp enters the stream every six bit periods.
// [RQ10] X.21 T and R changes are stamped 16 bit times late.
// [RQ11] A sent character starts two bit periods after its recorded time.
// [RQ12] A received character is stamped one character plus two bits after start.
// [RQ13] Last sync character adds one character; first of two adds another.
// [RQ14] Opening flag is stamped 26 bits late plus one per stuffed zero.
// [RQ15] Address byte is stamped 18 bits late plus stuffed zeros.
// [RQ16] Other frame bytes are stamped 34 bits late plus stuffed zeros.
// [RQ17] Check bytes are stamped 24 and 16 bits late plus stuffed zeros.
// [RQ18] Closing flag is stamped a fixed eight bit periods late.
// [RQ19] Resolution is 1.0, 0.5, 0.2 or 0.1 ms by selected rate band.
// [RQ20] Five event counters, any increment up to 65,535.
// [RQ21] Counters wrap past 65,535; overflow may step the next counter.
// [RQ22] Counters clear at start and on reset command, then hold zero.
// [RQ23] Counters are 16-bit registers with modulo-65536 addition.
module cts_capture_timing #(
    parameter int RES_CYC_A = `CTS_RES_CYC(`CTS_RES_A_NS),
    parameter int RES_CYC_B = `CTS_RES_CYC(`CTS_RES_B_NS),
    parameter int RES_CYC_C = `CTS_RES_CYC(`CTS_RES_C_NS),
    parameter int RES_CYC_D = `CTS_RES_CYC(`CTS_RES_D_NS)
) (
    input logic clk,
    input logic rst_b,
    input logic run_start,
    input logic stop_all,
    input logic timing_en,
    input logic [1:0] rate_sel,
    input logic [15:0] bit_div,
    input logic data_valid,
    input cts_pkg::cts_chr_t chr_in,
    input logic hl_req,
    input logic hl_last,
    input logic [5:0] hl_rd_idx,
    input cts_pkg::cts_tcmd_t tmr_cmd,
    input cts_pkg::cts_ccmd_t cnt_cmd,
    input logic [4:0] casc_en,
    output cts_pkg::cts_stamp_t stamp_out,
    output cts_pkg::cts_mark_t mark_out,
    output logic [19:0] cap_addr,
    output logic [6:0] hl_count,
    output logic [19:0] hl_rd_data,
    output logic [4:0][15:0] tmr_val,
    output logic tmr_meas_ok,
    output logic [4:0][15:0] cnt_val,
    output logic [16:0] cursor_range,
    output logic running
);
    import cts_pkg::*;

    // ****************************************
    // Elaboration checks
    // ****************************************
    generate
        if (RES_CYC_A < 2 || RES_CYC_B < 2 || RES_CYC_C < 2 || RES_CYC_D < 2 ||
            RES_CYC_A > 65535 || RES_CYC_B > 65535 || RES_CYC_C > 65535 || RES_CYC_D > 65535) begin : g_chk
            $error("cts_capture_timing: resolution divider out of range");
        end
    endgenerate

    // Stamp delay of one character in bit times
    function automatic logic signed [8:0] cts_delay(input cts_kind_t k, input logic [3:0] cb,
                                                    input logic [2:0] stf);
        logic [8:0] c;
        logic [8:0] s;
        c = {5'h00, cb};
        s = {6'h00, stf};
        case (k)
            CTS_K_COP_TX: cts_delay = `CTS_DLY_COP_TX; // RQ11
            CTS_K_COP_RX: cts_delay = c + `CTS_DLY_COP_RX; // RQ12
            CTS_K_SYNC_LAST: cts_delay = c + c + `CTS_DLY_COP_RX; // RQ13
            CTS_K_SYNC_FIRST2: cts_delay = c + c + c + `CTS_DLY_COP_RX; // RQ13
            CTS_K_OPEN: cts_delay = `CTS_DLY_OPEN + s; // RQ14
            CTS_K_ADDR: cts_delay = `CTS_DLY_ADDR + s; // RQ15
            CTS_K_DATA: cts_delay = `CTS_DLY_DATA + s; // RQ16
            CTS_K_FCS1: cts_delay = `CTS_DLY_FCS1 + s; // RQ17
            CTS_K_FCS2: cts_delay = `CTS_DLY_FCS2 + s; // RQ17
            CTS_K_CLOSE: cts_delay = `CTS_DLY_CLOSE; // RQ18
            default: cts_delay = `CTS_DLY_X21; // RQ10
        endcase
    endfunction

    // ****************************************
    // State
    // ****************************************
    cts_run_t st_q, st_d;
    logic tcap_q, tcap_d;
    logic [15:0] bit_cnt_q, bit_cnt_d;
    logic [2:0] six_q, six_d;
    logic [15:0] res_cnt_q, res_cnt_d;
    logic [3:0] msr_q, msr_d;
    logic [15:0] time_q, time_d;
    logic [15:0] share_q, share_d;
    cts_stamp_t stamp_q, stamp_d;
    cts_mark_t mark_q, mark_d;
    logic [19:0] addr_q, addr_d;
    logic [5:0] hl_wp_q, hl_wp_d;
    logic [6:0] hl_cnt_q, hl_cnt_d;
    logic [19:0] hl_rd_q, hl_rd_d;
    logic [19:0] hl_mem [`CTS_HL_DEPTH];
    logic [4:0] trun_q, trun_d;
    logic [4:0][15:0] tmr_q, tmr_d;
    logic [4:0][15:0] cnt_q, cnt_d;
    logic [4:0] ovf_q, ovf_d;
    logic [16:0] cur_q, cur_d;
    logic in_run;
    logic bit_tick;
    logic res_tick;
    logic ms_tick;
    logic stamp_now;
    logic hl_wr;
    logic [15:0] res_lim;
    logic [3:0] per_ms;

    assign in_run = (st_q == CTS_RUN);

    // Resolution band by rate selection
    always_comb begin
        case (rate_sel)
            2'h0: begin
                res_lim = 16'(RES_CYC_A); // RQ19
                per_ms = `CTS_PER_MS_A;
            end
            2'h1: begin
                res_lim = 16'(RES_CYC_B);
                per_ms = `CTS_PER_MS_B;
            end
            2'h2: begin
                res_lim = 16'(RES_CYC_C);
                per_ms = `CTS_PER_MS_C;
            end
            default: begin
                res_lim = 16'(RES_CYC_D);
                per_ms = `CTS_PER_MS_D;
            end
        endcase
    end

    // ****************************************
    // Run control
    // ****************************************
    always_comb begin
        st_d = st_q;
        tcap_d = tcap_q;
        if (run_start) begin
            st_d = CTS_RUN;
            tcap_d = timing_en; // RQ8
        end else begin
            case (st_q)
                CTS_RUN: if (stop_all) st_d = CTS_HALT; // RQ5
                default: st_d = st_q;
            endcase
        end
    end

    // ****************************************
    // Dividers and stamp insertion
    // ****************************************
    assign bit_tick = in_run && (bit_cnt_q >= bit_div);
    assign res_tick = in_run && (res_cnt_q >= res_lim - 16'h0001); // At or past the limit, so a band change cannot strand it
    assign ms_tick = res_tick && (msr_q >= per_ms - 4'h1);
    assign stamp_now = bit_tick && (six_q == `CTS_STAMP_BITS - 3'h1) && timing_en; // RQ9

    always_comb begin
        bit_cnt_d = bit_tick || !in_run ? 16'h0000 : bit_cnt_q + 16'h0001;
        six_d = six_q;
        if (!in_run) begin
            six_d = 3'h0;
        end else if (bit_tick) begin
            six_d = (six_q == `CTS_STAMP_BITS - 3'h1) ? 3'h0 : six_q + 3'h1;
        end
        res_cnt_d = res_tick || !in_run ? 16'h0000 : res_cnt_q + 16'h0001;
        msr_d = msr_q;
        if (!in_run) begin
            msr_d = 4'h0;
        end else if (res_tick) begin
            msr_d = ms_tick ? 4'h0 : msr_q + 4'h1;
        end
        time_d = run_start ? 16'h0000 : (res_tick ? time_q + 16'h0001 : time_q);
        stamp_d.valid = stamp_now; // RQ9
        stamp_d.time_val = time_q;
        cur_d = timing_en ? `CTS_CUR_ON : `CTS_CUR_OFF; // RQ7
    end

    // ****************************************
    // Capture buffer position and marks
    // ****************************************
    always_comb begin
        logic [20:0] nxt;
        nxt = {1'b0, addr_q} + {20'h00000, stamp_now} + {20'h00000, data_valid && in_run};
        addr_d = (nxt >= `CTS_BUF_WORDS) ? 20'(nxt - `CTS_BUF_WORDS) : nxt[19:0]; // RQ3
        if (run_start) begin
            addr_d = 20'h00000;
        end
        mark_d.valid = chr_in.valid && in_run;
        mark_d.delay_bits = cts_delay(chr_in.kind, chr_in.char_bits, chr_in.stuffed);
        mark_d.time_mark = time_q;
        share_d = share_q;
        if (chr_in.valid && in_run) begin
            case (chr_in.kind)
                CTS_K_OPEN, CTS_K_DATA: share_d = time_q; // RQ6
                CTS_K_ADDR, CTS_K_FCS1, CTS_K_FCS2, CTS_K_CLOSE: mark_d.time_mark = share_q; // RQ6
                default: share_d = share_q;
            endcase
        end
    end

    // ****************************************
    // Highlight record
    // ****************************************
    assign hl_wr = hl_req && hl_last && in_run; // RQ1

    always_comb begin
        hl_wp_d = hl_wr ? hl_wp_q + 6'h01 : hl_wp_q;
        hl_cnt_d = (hl_wr && hl_cnt_q != 7'h40) ? hl_cnt_q + 7'h01 : hl_cnt_q; // RQ1
        if (run_start) begin
            hl_wp_d = 6'h00;
            hl_cnt_d = 7'h00;
        end
        hl_rd_d = hl_mem[hl_rd_idx];
    end

    // Ring of the most recent positions
    always_ff @(posedge clk) begin
        if (hl_wr) begin
            hl_mem[hl_wp_q] <= addr_q;
        end
    end

    // ****************************************
    // Interval timers
    // ****************************************
    always_comb begin
        trun_d = trun_q;
        tmr_d = tmr_q;
        for (int i = 0; i < `CTS_TMR_N; i++) begin
            if (in_run && tcap_q && trun_q[i] && ms_tick && tmr_q[i] != `CTS_TMR_MAX) begin
                tmr_d[i] = tmr_q[i] + 16'h0001; // RQ2 RQ3
            end
            if (tmr_cmd.valid && in_run && tmr_cmd.idx == 3'(i)) begin
                case (tmr_cmd.op)
                    CTS_T_START: trun_d[i] = 1'b1;
                    CTS_T_STOP: trun_d[i] = 1'b0; // RQ5
                    default: tmr_d[i] = 16'h0000; // RQ4
                endcase
            end
        end
        if (in_run && stop_all) begin
            trun_d = 5'h00; // RQ5
        end
        if (run_start) begin
            trun_d = 5'h00;
            tmr_d = '0; // RQ4
        end
    end

    // ****************************************
    // Event counters
    // ****************************************
    always_comb begin
        logic [16:0] sum;
        logic [15:0] amt;
        sum = 17'h00000;
        amt = 16'h0000;
        cnt_d = cnt_q;
        ovf_d = 5'h00;
        for (int i = 0; i < `CTS_CNT_N; i++) begin
            amt = 16'h0000;
            if (cnt_cmd.valid && in_run && cnt_cmd.op == CTS_C_INC && cnt_cmd.idx == 3'(i)) begin
                amt = cnt_cmd.amount; // RQ20
            end else if (i > 0 && in_run && casc_en[i] && ovf_q[(i + 4) % 5]) begin
                amt = 16'h0001; // RQ21
            end
            sum = {1'b0, cnt_q[i]} + {1'b0, amt}; // RQ23
            cnt_d[i] = sum[15:0]; // RQ21
            ovf_d[i] = sum[16];
            if (cnt_cmd.valid && in_run && cnt_cmd.op == CTS_C_RESET && cnt_cmd.idx == 3'(i)) begin
                cnt_d[i] = 16'h0000; // RQ22
                ovf_d[i] = 1'b0;
            end
        end
        if (run_start) begin
            cnt_d = '0; // RQ22
            ovf_d = 5'h00;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_q <= CTS_IDLE;
            tcap_q <= 1'b0;
            bit_cnt_q <= 16'h0000;
            six_q <= 3'h0;
            res_cnt_q <= 16'h0000;
            msr_q <= 4'h0;
            time_q <= 16'h0000;
            share_q <= 16'h0000;
            stamp_q <= '0;
            mark_q <= '0;
            addr_q <= 20'h00000;
            hl_wp_q <= 6'h00;
            hl_cnt_q <= 7'h00;
            hl_rd_q <= 20'h00000;
            trun_q <= 5'h00;
            tmr_q <= '0;
            cnt_q <= '0;
            ovf_q <= 5'h00;
            cur_q <= `CTS_CUR_ON;
        end else begin
            st_q <= st_d;
            tcap_q <= tcap_d;
            bit_cnt_q <= bit_cnt_d;
            six_q <= six_d;
            res_cnt_q <= res_cnt_d;
            msr_q <= msr_d;
            time_q <= time_d;
            share_q <= share_d;
            stamp_q <= stamp_d;
            mark_q <= mark_d;
            addr_q <= addr_d;
            hl_wp_q <= hl_wp_d;
            hl_cnt_q <= hl_cnt_d;
            hl_rd_q <= hl_rd_d;
            trun_q <= trun_d;
            tmr_q <= tmr_d;
            cnt_q <= cnt_d;
            ovf_q <= ovf_d;
            cur_q <= cur_d;
        end
    end

    // Outputs
    assign stamp_out = stamp_q;
    assign mark_out = mark_q;
    assign cap_addr = addr_q;
    assign hl_count = hl_cnt_q;
    assign hl_rd_data = hl_rd_q;
    assign tmr_val = tmr_q;
    assign tmr_meas_ok = tcap_q;
    assign cnt_val = cnt_q;
    assign cursor_range = cur_q;
    assign running = in_run;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_hl_cnt;
        hl_wr && !run_start && hl_cnt_q < 7'h40 |=> hl_cnt_q == $past(hl_cnt_q) + 7'h01 && hl_cnt_q <= 7'h40;
    endproperty
    a_hl_cnt: assert property (p_hl_cnt) else $error("highlight count wrong"); // RQ1

    property p_tmr_clr;
        run_start |=> tmr_q == '0 && cnt_q == '0 ##1 tmr_q[0] == 16'h0000;
    endproperty
    a_tmr_clr: assert property (p_tmr_clr) else $error("timers not cleared at start"); // RQ4

    property p_tmr_stop;
        tmr_cmd.valid && tmr_cmd.op == CTS_T_STOP && tmr_cmd.idx == 3'h0 && in_run && !run_start
            |=> ##1 $stable(tmr_q[0]) [*3];
    endproperty
    a_tmr_stop: assert property (p_tmr_stop) else $error("stopped timer moved"); // RQ5

    property p_no_meas;
        !tcap_q && !run_start && !(tmr_cmd.valid && tmr_cmd.op == CTS_T_RESET) |=> $stable(tmr_q);
    endproperty
    a_no_meas: assert property (p_no_meas) else $error("timer moved with timing off"); // RQ8

    property p_stamp_off;
        !timing_en |=> !stamp_q.valid;
    endproperty
    a_stamp_off: assert property (p_stamp_off) else $error("stamp with timing off"); // RQ9

    property p_cursor;
        ##1 cur_q == ($past(timing_en) ? 17'h10000 : 17'h00040);
    endproperty
    a_cursor: assert property (p_cursor) else $error("cursor range wrong"); // RQ7

    property p_open_dly;
        chr_in.valid && in_run && chr_in.kind == CTS_K_OPEN && chr_in.stuffed == 3'h2
            |=> mark_q.valid && mark_q.delay_bits == 9'sd28;
    endproperty
    a_open_dly: assert property (p_open_dly) else $error("open flag delay wrong"); // RQ14

    property p_close_dly;
        chr_in.valid && in_run && chr_in.kind == CTS_K_CLOSE |=> mark_q.delay_bits == 9'sd8;
    endproperty
    a_close_dly: assert property (p_close_dly) else $error("close flag delay wrong"); // RQ18

    property p_share;
        chr_in.valid && in_run && chr_in.kind == CTS_K_OPEN ##1
            chr_in.valid && in_run && chr_in.kind == CTS_K_ADDR |=> mark_q.time_mark == $past(mark_q.time_mark);
    endproperty
    a_share: assert property (p_share) else $error("address mark differs from flag"); // RQ6

    property p_dec;
        cnt_cmd.valid && in_run && !run_start && cnt_cmd.op == CTS_C_INC && cnt_cmd.idx == 3'h1 &&
            cnt_cmd.amount == 16'hffff |=> cnt_q[1] == $past(cnt_q[1]) - 16'h0001;
    endproperty
    a_dec: assert property (p_dec) else $error("counter decrement wrong"); // RQ21

    property p_cnt_rst;
        cnt_cmd.valid && in_run && cnt_cmd.op == CTS_C_RESET && cnt_cmd.idx == 3'h2 &&
            !(casc_en[2] && ovf_q[1]) |=> cnt_q[2] == 16'h0000;
    endproperty
    a_cnt_rst: assert property (p_cnt_rst) else $error("counter reset wrong"); // RQ22

    c_stamp: cover property (stamp_q.valid ##[1:200] stamp_q.valid);
    c_full_hl: cover property (hl_cnt_q == 7'h40);
    c_wrap: cover property (ovf_q[0] && casc_en[1]);
    c_tmr: cover property (tmr_q[0] != 16'h0000 && !trun_q[0]);

endmodule

// File: src/cts_regs.svh
`ifndef CTS_REGS_SVH
`define CTS_REGS_SVH

// ****************************************
// Sizes
// ****************************************
`define CTS_TMR_N 5
`define CTS_CNT_N 5
`define CTS_HL_DEPTH 64
`define CTS_BUF_WORDS 21'h0c0000
`define CTS_STAMP_BITS 3'h6
`define CTS_CUR_ON 17'h10000
`define CTS_CUR_OFF 17'h00040
`define CTS_TMR_MAX 16'hffff

// ****************************************
// Stamp delays in bit times
// ****************************************
`define CTS_DLY_X21 9'h010
`define CTS_DLY_COP_TX 9'h1fe
`define CTS_DLY_COP_RX 9'h002
`define CTS_DLY_OPEN 9'h01a
`define CTS_DLY_ADDR 9'h012
`define CTS_DLY_DATA 9'h022
`define CTS_DLY_FCS1 9'h018
`define CTS_DLY_FCS2 9'h010
`define CTS_DLY_CLOSE 9'h008

// ****************************************
// Timing
// ****************************************
`define CTS_CLK_NS 40
`define CTS_RES_A_NS 1000000
`define CTS_RES_B_NS 500000
`define CTS_RES_C_NS 200000
`define CTS_RES_D_NS 100000
`define CTS_RES_CYC(ns) (((ns) + `CTS_CLK_NS - 1) / `CTS_CLK_NS)
`define CTS_PER_MS_A 4'h1
`define CTS_PER_MS_B 4'h2
`define CTS_PER_MS_C 4'h5
`define CTS_PER_MS_D 4'ha

`endif

// File: src/cts_pkg.sv
package cts_pkg;

    typedef enum logic [3:0] {
        CTS_K_COP_TX, CTS_K_COP_RX, CTS_K_SYNC_LAST, CTS_K_SYNC_FIRST2,
        CTS_K_OPEN, CTS_K_ADDR, CTS_K_DATA, CTS_K_FCS1, CTS_K_FCS2,
        CTS_K_CLOSE, CTS_K_X21
    } cts_kind_t;

    typedef enum logic [1:0] {CTS_T_START, CTS_T_STOP, CTS_T_RESET} cts_top_t;
    typedef enum logic {CTS_C_INC, CTS_C_RESET} cts_cop_t;
    typedef enum logic [1:0] {CTS_IDLE, CTS_RUN, CTS_HALT} cts_run_t;

    typedef struct packed {
        logic valid;
        cts_kind_t kind;
        logic [3:0] char_bits;
        logic [2:0] stuffed;
    } cts_chr_t;

    typedef struct packed {
        logic valid;
        logic signed [8:0] delay_bits;
        logic [15:0] time_mark;
    } cts_mark_t;

    typedef struct packed {
        logic valid;
        logic [15:0] time_val;
    } cts_stamp_t;

    typedef struct packed {
        logic valid;
        cts_top_t op;
        logic [2:0] idx;
    } cts_tcmd_t;

    typedef struct packed {
        logic valid;
        cts_cop_t op;
        logic [2:0] idx;
        logic [15:0] amount;
    } cts_ccmd_t;

endpackage

// File: verification/cts_line_model.sv
`timescale 1ns/1ps

// ********************************
// Monitored line: character events
// ********************************
module cts_line_model (
    input wire logic clk,
    output cts_pkg::cts_chr_t chr,
    output logic word_valid
);
    import cts_pkg::*;

    // Line quiet until the first character
    initial begin
        chr = '0;
        word_valid = 1'b0;
    end

    // One character with its captured word, then released fields flip
    task automatic send(input cts_kind_t kind, input logic [3:0] cb, input logic [2:0] s);
        @(negedge clk);
        chr <= '{1'b1, kind, cb, s};
        word_valid <= 1'b1;
        @(negedge clk);
        chr <= '{1'b0, cts_kind_t'(~kind), ~cb, ~s};
        word_valid <= 1'b0;
    endtask

    // Two characters back to back, each with its captured word
    task automatic send2(input cts_kind_t k0, input cts_kind_t k1, input logic [3:0] cb, input logic [2:0] s);
        @(negedge clk);
        chr <= '{1'b1, k0, cb, s};
        word_valid <= 1'b1;
        send(k1, cb, s);
    endtask
endmodule

// File: verification/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    import cts_pkg::*;
    logic clk, rst_b, run_start, stop_all, timing_en, data_valid, hl_req, hl_last, tmr_meas_ok, running;
    logic [1:0] rate_sel;
    logic [15:0] bit_div, t0, mk;
    logic [5:0] hl_rd_idx;
    logic [4:0] casc_en;
    logic [19:0] cap_addr, hl_rd_data, a0;
    logic [6:0] hl_count;
    logic [4:0][15:0] tmr_val, cnt_val;
    logic [16:0] cursor_range;
    logic [31:0] lfsr;
    logic [15:0] exp_cnt [5];
    cts_chr_t chr_in;
    cts_tcmd_t tmr_cmd;
    cts_ccmd_t cnt_cmd;
    cts_stamp_t stamp_out;
    cts_mark_t mark_out;
    int err_total, comparisons, n, w;

    // ********************************
    // Design and line model
    // ********************************
    cts_capture_timing #(.RES_CYC_A(20), .RES_CYC_B(10), .RES_CYC_C(4), .RES_CYC_D(2)) cts_capture_timing_inst (
        .clk(clk), .rst_b(rst_b), .run_start(run_start), .stop_all(stop_all), .timing_en(timing_en),
        .rate_sel(rate_sel), .bit_div(bit_div), .data_valid(data_valid), .chr_in(chr_in), .hl_req(hl_req),
        .hl_last(hl_last), .hl_rd_idx(hl_rd_idx), .tmr_cmd(tmr_cmd), .cnt_cmd(cnt_cmd), .casc_en(casc_en),
        .stamp_out(stamp_out), .mark_out(mark_out), .cap_addr(cap_addr), .hl_count(hl_count),
        .hl_rd_data(hl_rd_data), .tmr_val(tmr_val), .tmr_meas_ok(tmr_meas_ok), .cnt_val(cnt_val),
        .cursor_range(cursor_range), .running(running));
    cts_line_model cts_line_model_inst (.clk(clk), .chr(chr_in), .word_valid(data_valid));

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ********************************
    // Checking and expectations
    // ********************************
    task automatic final_report();
        if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic chk_rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi, input string msg);
        comparisons++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            err_total++;
            $display("wrong value %0t %s got %h", $time, msg, got);
        end
    endtask

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // Stamp delay in bit times per character kind
    function automatic logic [8:0] exp_dly(input cts_kind_t k, input logic [3:0] cb, input logic [2:0] s);
        case (k)
            CTS_K_COP_TX: return 9'h1fe;
            CTS_K_COP_RX: return 9'(cb) + 9'h002;
            CTS_K_SYNC_LAST: return 9'(cb) * 9'h002 + 9'h002;
            CTS_K_SYNC_FIRST2: return 9'(cb) * 9'h003 + 9'h002;
            CTS_K_OPEN: return 9'h01a + 9'(s);
            CTS_K_ADDR: return 9'h012 + 9'(s);
            CTS_K_DATA: return 9'h022 + 9'(s);
            CTS_K_FCS1: return 9'h018 + 9'(s);
            CTS_K_FCS2: return 9'h010 + 9'(s);
            CTS_K_CLOSE: return 9'h008;
            default: return 9'h010;
        endcase
    endfunction

    // ********************************
    // Command drivers, falling edge
    // ********************************
    task automatic cnt_op(input cts_cop_t op, input int i, input logic [15:0] amt);
        @(negedge clk);
        cnt_cmd <= '{1'b1, op, 3'(i), amt};
        @(negedge clk);
        cnt_cmd.valid <= 1'b0;
        exp_cnt[i] = (op == CTS_C_RESET) ? 16'h0000 : exp_cnt[i] + amt;
    endtask

    task automatic tmr_op(input cts_top_t op, input int i);
        @(negedge clk);
        tmr_cmd <= '{1'b1, op, 3'(i)};
        @(negedge clk);
        tmr_cmd.valid <= 1'b0;
    endtask

    task automatic start(input logic te);
        @(negedge clk);
        run_start <= 1'b1;
        timing_en <= te;
        @(negedge clk);
        run_start <= 1'b0;
        exp_cnt = '{default: 16'h0000};
        @(negedge clk);
        chk(running, 1, "run");
        chk(cursor_range, te ? 20'h10000 : 20'h00040, "cursor");
        chk(tmr_meas_ok, te, "meas");
        for (int i = 0; i < 5; i++) begin
            chk(cnt_val[i], 0, "cnt start");
            chk(tmr_val[i], 0, "tmr start");
        end
    endtask

    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        final_report();
    end

    // ********************************
    // Scenarios
    // ********************************
    initial begin
        rst_b = 1'b0;
        run_start = 1'b0;
        stop_all = 1'b0;
        timing_en = 1'b1;
        rate_sel = 2'h0;
        bit_div = 16'h0001;
        hl_req = 1'b0;
        hl_last = 1'b0;
        hl_rd_idx = 6'h00;
        casc_en = 5'h00;
        tmr_cmd = '0;
        cnt_cmd = '0;
        lfsr = 32'h39b6;
        err_total = 0;
        comparisons = 0;
        repeat (10) @(negedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        chk(cursor_range, 20'h10000, "cursor rst");
        chk(running, 0, "idle");
        start(1'b1);
        // Random increments and resets, then wrap and cascade
        for (n = 0; n < 40; n++) begin
            lfsr = lfsr_next(lfsr);
            w = lfsr[10:8] % 5;
            cnt_op(lfsr[7:4] == 4'h0 ? CTS_C_RESET : CTS_C_INC, w, lfsr[31:16]);
            chk(cnt_val[w], exp_cnt[w], "cnt");
        end
        cnt_op(CTS_C_INC, 1, 16'hffff);
        chk(cnt_val[1], exp_cnt[1], "cnt dec1");
        cnt_op(CTS_C_INC, 2, 16'hfffe);
        chk(cnt_val[2], exp_cnt[2], "cnt dec2");
        casc_en <= 5'h02;
        cnt_op(CTS_C_RESET, 1, 16'h0000);
        cnt_op(CTS_C_RESET, 0, 16'h0000);
        cnt_op(CTS_C_INC, 0, 16'hffff);
        cnt_op(CTS_C_INC, 0, 16'h0001);
        @(negedge clk);
        chk(cnt_val[0], 0, "wrap");
        chk(cnt_val[1], 1, "cascade");
        cnt_op(CTS_C_RESET, 3, 16'h0000);
        repeat (20) @(negedge clk);
        chk(cnt_val[3], 0, "cnt held");
        // Highlights: only a final character marks, ring depth caps the count
        hl_req <= 1'b1;
        @(negedge clk);
        @(negedge clk);
        chk(hl_count, 0, "hl not last");
        hl_last <= 1'b1;
        repeat (66) begin
            a0 = cap_addr;
            @(negedge clk);
        end
        hl_req <= 1'b0;
        hl_rd_idx <= 6'h01;
        @(negedge clk);
        chk(hl_count, 64, "hl sat");
        chk(hl_rd_data, a0, "hl pos");
        // Every character kind, frame kinds in frame order, stamps held off
        timing_en <= 1'b0;
        a0 = cap_addr;
        for (int k = 0; k < 11; k++) begin
            lfsr = lfsr_next(lfsr);
            cts_line_model_inst.send(cts_kind_t'(k), {2'b10, lfsr[1:0]}, lfsr[4:2]);
            for (w = 0; w < 4 && mark_out.valid !== 1'b1; w++) @(negedge clk);
            chk(mark_out.valid, 1, "mark");
            chk({mark_out.delay_bits}, exp_dly(cts_kind_t'(k), {2'b10, lfsr[1:0]}, lfsr[4:2]), "dly");
            if (k == 4 || k == 6) mk = mark_out.time_mark;
            if (k == 5 || (k > 6 && k < 10)) chk(mark_out.time_mark, mk, "shared");
            repeat (30) @(negedge clk);
        end
        cts_line_model_inst.send2(CTS_K_OPEN, CTS_K_ADDR, 4'h8, 3'h2);
        chk({mark_out.delay_bits}, exp_dly(CTS_K_ADDR, 4'h8, 3'h2), "addr dly");
        chk(cap_addr, a0 + 20'd13, "words");
        timing_en <= 1'b1;
        // Timers in every resolution band, stop keeps the value
        for (n = 0; n < 4; n++) begin
            rate_sel <= 2'(n);
            tmr_op(CTS_T_START, n);
            repeat (200) @(negedge clk);
            tmr_op(CTS_T_STOP, n);
            t0 = tmr_val[n];
            chk_rng(t0, 16'd9, 16'd11, "tmr ms");
            repeat (40) @(negedge clk);
            chk(tmr_val[n], t0, "tmr hold");
        end
        tmr_op(CTS_T_RESET, 0);
        chk(tmr_val[0], 0, "tmr rst");
        // Stamp spacing at the finest band
        n = 0;
        a0 = cap_addr;
        for (w = 0; w < 120; w++) begin
            @(negedge clk);
            if (stamp_out.valid === 1'b1) begin
                if (n > 0) chk(stamp_out.time_val - t0, 6, "stamp step");
                t0 = stamp_out.time_val;
                n++;
            end
        end
        chk(n, 10, "stamps");
        chk(cap_addr - a0, 20'd10, "stamps stored");
        tmr_op(CTS_T_START, 4);
        repeat (60) @(negedge clk);
        stop_all <= 1'b1;
        @(negedge clk);
        stop_all <= 1'b0;
        @(negedge clk);
        t0 = tmr_val[4];
        chk(running, 0, "halt");
        chk_rng(t0, 16'd2, 16'd4, "tmr before halt");
        repeat (40) @(negedge clk);
        chk(tmr_val[4], t0, "halt hold");
        // Capture without timing information
        start(1'b0);
        tmr_op(CTS_T_START, 0);
        repeat (100) @(negedge clk);
        chk(tmr_val[0], 0, "no meas");
        final_report();
    end
endmodule
